// File: shared/msm_cfg.svh
// Purpose: Offsets, bit positions and reset values of the MAC status block
// Assumes: Byte addresses on an 8-bit register address
// Notes: Alias select sits in address bits 3:2
`ifndef MSM_CFG_SVH
`define MSM_CFG_SVH
`define MSM_OFF_STATUS 4'h0
`define MSM_OFF_MIND 4'h1
`define MSM_OFF_CON1 4'h2
`define MSM_OFF_IEN 4'h3
`define MSM_OFF_RXST 4'h4
`define MSM_ALIAS_PLAIN 2'h0
`define MSM_ALIAS_CLR 2'h1
`define MSM_ALIAS_SET 2'h2
`define MSM_ALIAS_INV 2'h3
`define MSM_CNT_MAX 8'hff
`define MSM_CNT_ZERO 8'h00
`define MSM_CNT_ONE 8'h01
`define MSM_RST_CNT 8'h00
`define MSM_RST_WORD 32'h0000_0000
`define MSM_LO_HALF 32'h0000_ffff
`define MSM_HI_HALF 32'hffff_0000
`define MSM_ALL_LANES 32'hffff_ffff
`define MSM_STAT_CNT_LSB 16
`define MSM_STAT_BUSY 7
`define MSM_STAT_TRANSMIT_BUSY_FLAG 6
`define MSM_STAT_RECEIVE_BUSY_FLAG 5
`define MSM_MIND_LINK 3
`define MSM_MIND_NV 2
`define MSM_MIND_SCAN 1
`define MSM_MIND_BUSY 0
`define MSM_CON1_ON 15
`define MSM_CON1_AFC 7
`define MSM_CON1_DEC 0
`define MSM_IEN_PKT 6
`endif

// File: shared/msm_pkg.sv
// Purpose: Types shared by the MAC status block
// Assumes: Constants come from msm_cfg.svh
// Notes: Access size follows the register port's size code
package msm_pkg;
  typedef enum logic [1:0] {sz_byte, sz_half, sz_word, sz_rsv} msm_size_e;

  typedef struct packed {
    logic wr;
    logic rd;
    msm_size_e size;
    logic [7:0] addr;
    logic [31:0] wdata;
  } msm_req_s;

  typedef struct packed {
    logic pkt_done;
    logic [7:0] desc_used;
    logic tx_active;
    logic rx_active;
    logic txn_pending;
  } msm_rx_s;

  typedef struct packed {
    logic busy;
    logic scan;
    logic rd_start;
    logic rd_done;
    logic rd_phy_stat;
    logic link_fail;
  } msm_mgmt_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic on;
    logic afc;
    logic pkt_ie;
    logic link_fail;
    logic rd_pend;
    logic scan;
    logic mbusy;
    logic eth_busy;
    logic tx_busy;
    logic rx_busy;
    logic halt;
    logic pend;
    logic irq;
    logic rvalid;
    logic rd_mind;
    logic [31:0] rdata;
  } msm_state_s;
endpackage

// File: logic/msm_status.sv
// Purpose: Buffer count, busy flags and management indicators of the MAC
// Assumes: All inputs synchronous to clk; one access per cycle
// Notes: Registers reached by a simple word/halfword port with aliases
//
// Notes on behaviour
// - Good packet adds its descriptor count
// - Increment at maximum stays at maximum
// - Decrement at zero stays at zero
// - Simultaneous increment and decrement keep count
// - Flow control on: halt receive at maximum
// - Flow control off: receive keeps running
// - Pending flag when count non-zero, gated interrupt
// - Descriptor start address write clears count
// - Switching off keeps the count
// - Module busy while on or finishing
// - Tx/Rx busy follow activity, cleared when off
// - Link fail from last PHY status read
// - Read not valid from start to completion
// - Scan flag while scan operation runs
// - Management busy during read or write cycle
// - Halfword and word accesses only, bytes ignored
// - Unused indicator bits read zero
`include "msm_cfg.svh"

module msm_status (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire msm_pkg::msm_req_s req,
  output logic [31:0] rdata,
  output logic rvalid,
  // Receive and transmit engines
  input wire msm_pkg::msm_rx_s rx,
  // Management engine
  input wire msm_pkg::msm_mgmt_s mgmt,
  // Status towards the datapath
  output logic module_on,
  output logic rx_halt,
  output logic packet_pending_flag,
  output logic packet_pending_irq
);

  msm_pkg::msm_state_s q;
  msm_pkg::msm_state_s next_q;

  logic acc_ok;
  logic wr_ok;
  logic [3:0] base;
  logic [1:0] alias_sel;
  logic [31:0] lane_mask;
  logic [31:0] con1_word;
  logic [31:0] con1_new;
  logic [31:0] ien_word;
  logic [31:0] ien_new;
  logic [31:0] mind_word;
  logic [31:0] mind_new;
  logic [31:0] stat_word;
  logic dec_strobe;
  logic rxst_wr;
  logic inc;
  logic [8:0] sum;

  // Alias write: plain, clear, set or invert under the lane mask
  function automatic logic [31:0] apply_alias(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [31:0] mask,
    input logic [1:0] sel
  );
    logic [31:0] m;
    m = wd & mask;
    case (sel)
      `MSM_ALIAS_CLR: apply_alias = old & ~m;
      `MSM_ALIAS_SET: apply_alias = old | m;
      `MSM_ALIAS_INV: apply_alias = old ^ m;
      default: apply_alias = (old & ~mask) | m;
    endcase
  endfunction

  // Address decode and access size
  always_comb begin
    base = req.addr[7:4];
    alias_sel = req.addr[3:2];
    acc_ok = (req.size == msm_pkg::sz_half) || (req.size == msm_pkg::sz_word);
    wr_ok = req.wr && acc_ok;
    if (req.size == msm_pkg::sz_half) begin
      lane_mask = req.addr[1] ? `MSM_HI_HALF : `MSM_LO_HALF;
    end else begin
      lane_mask = `MSM_ALL_LANES;
    end
  end

  // Current register images
  always_comb begin
    stat_word = `MSM_RST_WORD;
    stat_word[`MSM_STAT_CNT_LSB +: 8] = q.cnt;
    stat_word[`MSM_STAT_BUSY] = q.eth_busy;
    stat_word[`MSM_STAT_TRANSMIT_BUSY_FLAG] = q.tx_busy;
    stat_word[`MSM_STAT_RECEIVE_BUSY_FLAG] = q.rx_busy;
    mind_word = `MSM_RST_WORD;
    mind_word[`MSM_MIND_LINK] = q.link_fail;
    mind_word[`MSM_MIND_NV] = q.rd_pend;
    mind_word[`MSM_MIND_SCAN] = q.scan;
    mind_word[`MSM_MIND_BUSY] = q.mbusy;
    con1_word = `MSM_RST_WORD;
    con1_word[`MSM_CON1_ON] = q.on;
    con1_word[`MSM_CON1_AFC] = q.afc;
    ien_word = `MSM_RST_WORD;
    ien_word[`MSM_IEN_PKT] = q.pkt_ie;
  end

  // Writes through the aliases
  always_comb begin
    con1_new = con1_word;
    ien_new = ien_word;
    mind_new = mind_word;
    rxst_wr = 1'b0;
    if (wr_ok) begin
      case (base)
        `MSM_OFF_CON1: con1_new = apply_alias(con1_word, req.wdata, lane_mask, alias_sel);
        `MSM_OFF_IEN: ien_new = apply_alias(ien_word, req.wdata, lane_mask, alias_sel);
        `MSM_OFF_MIND: mind_new = apply_alias(mind_word, req.wdata, lane_mask, alias_sel);
        `MSM_OFF_RXST: rxst_wr = 1'b1;
        default: rxst_wr = 1'b0;
      endcase
    end
    // Stored decrement bit is always zero, so any alias that yields one fires
    dec_strobe = con1_new[`MSM_CON1_DEC];
  end

  // State update
  always_comb begin
    next_q = q;
    inc = rx.pkt_done;
    sum = {1'b0, q.cnt} + {1'b0, rx.desc_used};
    next_q.on = con1_new[`MSM_CON1_ON];
    next_q.afc = con1_new[`MSM_CON1_AFC];
    next_q.pkt_ie = ien_new[`MSM_IEN_PKT];
    next_q.link_fail = mind_new[`MSM_MIND_LINK];

    // Buffer count; module off does not touch it
    if (rxst_wr) begin
      next_q.cnt = `MSM_CNT_ZERO;
    end else if (inc && dec_strobe) begin
      next_q.cnt = q.cnt;
    end else if (inc) begin
      next_q.cnt = sum[8] ? `MSM_CNT_MAX : sum[7:0];
    end else if (dec_strobe) begin
      if (q.cnt != `MSM_CNT_ZERO) begin
        next_q.cnt = q.cnt - `MSM_CNT_ONE;
      end
    end

    // Halt only with flow control; otherwise count just saturates
    next_q.halt = next_q.afc && (next_q.cnt == `MSM_CNT_MAX);
    next_q.pend = (next_q.cnt != `MSM_CNT_ZERO);
    next_q.irq = next_q.pend && next_q.pkt_ie;

    // Busy flags
    next_q.eth_busy = next_q.on || rx.txn_pending;
    next_q.tx_busy = next_q.on && rx.tx_active;
    next_q.rx_busy = next_q.on && rx.rx_active;

    // Management indicators; hardware events win over software writes
    if (mgmt.rd_done && mgmt.rd_phy_stat) begin
      next_q.link_fail = mgmt.link_fail;
    end
    if (mgmt.rd_start) begin
      next_q.rd_pend = 1'b1;
    end else if (mgmt.rd_done) begin
      next_q.rd_pend = 1'b0;
    end else begin
      next_q.rd_pend = mind_new[`MSM_MIND_NV];
    end
    next_q.scan = mgmt.scan;
    next_q.mbusy = mgmt.busy;

    // Read answer one cycle later; byte reads get no answer
    next_q.rvalid = req.rd && acc_ok;
    next_q.rd_mind = 1'b0;
    next_q.rdata = q.rdata;
    if (req.rd && acc_ok) begin
      case (base)
        `MSM_OFF_STATUS: next_q.rdata = stat_word;
        `MSM_OFF_MIND: begin
          next_q.rdata = mind_word;
          next_q.rd_mind = 1'b1;
        end
        `MSM_OFF_CON1: next_q.rdata = con1_word;
        `MSM_OFF_IEN: next_q.rdata = ien_word;
        default: next_q.rdata = `MSM_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      q <= '0;
      q.cnt <= `MSM_RST_CNT;
      q.rdata <= `MSM_RST_WORD;
    end else begin
      q <= next_q;
    end
  end

  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
  assign module_on = q.on;
  assign rx_halt = q.halt;
  assign packet_pending_flag = q.pend;
  assign packet_pending_irq = q.irq;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  logic con1_set_wr;
  logic ien_set_wr;
  assign con1_set_wr = wr_ok && (base == `MSM_OFF_CON1);
  assign ien_set_wr = wr_ok && (base == `MSM_OFF_IEN) && (alias_sel == `MSM_ALIAS_SET)
    && lane_mask[`MSM_IEN_PKT] && req.wdata[`MSM_IEN_PKT];

  property p_inc_adds;
    inc && !dec_strobe && !rxst_wr && !sum[8]
      |=> q.cnt == $past(sum[7:0]);
  endproperty
  a_inc_adds: assert property (p_inc_adds) else $error("count add wrong");

  property p_sat_max;
    (q.cnt == `MSM_CNT_MAX) && inc && !dec_strobe && !rxst_wr
      |=> q.cnt == `MSM_CNT_MAX;
  endproperty
  a_sat_max: assert property (p_sat_max) else $error("count wrapped at max");

  property p_no_under;
    (q.cnt == `MSM_CNT_ZERO) && dec_strobe && !inc && !rxst_wr
      |=> q.cnt == `MSM_CNT_ZERO;
  endproperty
  a_no_under: assert property (p_no_under) else $error("count wrapped at zero");

  property p_dec_one;
    (q.cnt != `MSM_CNT_ZERO) && dec_strobe && !inc && !rxst_wr
      |=> q.cnt == $past(q.cnt) - `MSM_CNT_ONE;
  endproperty
  a_dec_one: assert property (p_dec_one) else $error("decrement wrong");

  property p_both_hold;
    inc && dec_strobe && !rxst_wr |=> $stable(q.cnt);
  endproperty
  a_both_hold: assert property (p_both_hold) else $error("count moved on both");

  property p_halt;
    q.halt == (q.afc && (q.cnt == `MSM_CNT_MAX));
  endproperty
  a_halt: assert property (p_halt) else $error("halt mismatch");

  property p_no_halt_off;
    !q.afc |-> !q.halt;
  endproperty
  a_no_halt_off: assert property (p_no_halt_off) else $error("halt without flow ctl");

  property p_pend;
    (q.pend == (q.cnt != `MSM_CNT_ZERO)) && (q.irq == (q.pend && q.pkt_ie));
  endproperty
  a_pend: assert property (p_pend) else $error("pending or irq wrong");

  property p_rxst_clear;
    rxst_wr |=> q.cnt == `MSM_CNT_ZERO;
  endproperty
  a_rxst_clear: assert property (p_rxst_clear) else $error("count not cleared");

  property p_off_keeps;
    con1_set_wr && q.on && !con1_new[`MSM_CON1_ON] && !inc && !dec_strobe
      |=> $stable(q.cnt) && !q.on;
  endproperty
  a_off_keeps: assert property (p_off_keeps) else $error("count lost at off");

  property p_busy;
    q.on |-> q.eth_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("module busy low while on");

  property p_txrx_off;
    !q.on |-> !q.tx_busy && !q.rx_busy;
  endproperty
  a_txrx_off: assert property (p_txrx_off) else $error("tx or rx busy while off");

  property p_link;
    mgmt.rd_done && mgmt.rd_phy_stat |=> q.link_fail == $past(mgmt.link_fail);
  endproperty
  a_link: assert property (p_link) else $error("link fail not captured");

  property p_nv;
    mgmt.rd_start ##1 !mgmt.rd_done [*2] |-> q.rd_pend;
  endproperty
  a_nv: assert property (p_nv) else $error("read pending dropped");

  property p_scan_busy;
    mgmt.scan && mgmt.busy |=> q.scan && q.mbusy;
  endproperty
  a_scan_busy: assert property (p_scan_busy) else $error("scan or busy missed");

  property p_byte_ignored;
    req.size == msm_pkg::sz_byte |=> !q.rvalid && $stable(q.on) && $stable(q.pkt_ie);
  endproperty
  a_byte_ignored: assert property (p_byte_ignored) else $error("byte access acted");

  property p_mind_zero;
    q.rvalid && q.rd_mind |-> q.rdata[31:4] == 28'h000_0000;
  endproperty
  a_mind_zero: assert property (p_mind_zero) else $error("unused bits set");

  property p_set_alias;
    ien_set_wr |=> q.pkt_ie;
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias failed");

  property p_txrx_follow;
    (q.tx_busy == (q.on && $past(rx.tx_active)))
      && (q.rx_busy == (q.on && $past(rx.rx_active)));
  endproperty
  a_txrx_follow: assert property (p_txrx_follow) else $error("tx or rx busy wrong");

  property p_finish_busy;
    rx.txn_pending |=> q.eth_busy;
  endproperty
  a_finish_busy: assert property (p_finish_busy) else $error("busy low while finishing");

  property p_nv_done;
    mgmt.rd_done && !mgmt.rd_start |=> !q.rd_pend;
  endproperty
  a_nv_done: assert property (p_nv_done) else $error("read pending stuck");

  property p_rvalid;
    req.rd && acc_ok |=> q.rvalid;
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");

  c_saturate: cover property (q.cnt == `MSM_CNT_MAX && inc);
  c_halt: cover property (q.halt ##[1:20] !q.halt);
  c_both: cover property (inc && dec_strobe);
  c_rxst: cover property (rxst_wr && q.cnt != `MSM_CNT_ZERO);
  c_mgmt_read: cover property (mgmt.rd_start ##[1:8] mgmt.rd_done);

endmodule

// File: verif/msm_mgmt_model.sv
// Purpose: Behavioural management engine facing the status block
// Assumes: One PHY status read for each go request, scan level passed through
// Notes: Link value is only valid with the completion pulse, toggles otherwise
module msm_mgmt_model (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Commands from the bench
  input wire logic go,
  input wire logic scan_on,
  input wire logic lf,
  // Engine status
  output msm_pkg::msm_mgmt_s mgmt
);
  timeunit 1ns;
  timeprecision 1ps;
  int step;
  always @(posedge clk) begin
    if (srst) begin
      mgmt <= '0;
      step <= 0;
    end else begin
      mgmt.scan <= scan_on;
      mgmt.rd_start <= go && step == 0;
      mgmt.busy <= (go && step == 0) || step == 1 || step == 2;
      mgmt.rd_done <= step == 3;
      mgmt.rd_phy_stat <= step == 3;
      // Stale value inverted so a late capture shows up
      mgmt.link_fail <= (step == 3) ? lf : ~mgmt.link_fail;
      step <= (step == 3 || (step == 0 && !go)) ? 0 : step + 1;
    end
  end
endmodule

// File: verif/testbench.sv
// Purpose: Self-checking bench for the MAC status block
// Assumes: Register port and engine inputs driven at the falling edge
// Notes: Management engine comes from msm_mgmt_model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, srst, go, scan_on, lf;
  msm_pkg::msm_req_s req;
  msm_pkg::msm_rx_s rx;
  msm_pkg::msm_mgmt_s mgmt;
  logic [31:0] rdata, d;
  logic rvalid, module_on, rx_halt, pend, irq;
  int err_count = 0;
  int n_compared = 0;

  msm_status i_dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .rvalid(rvalid),
    .rx(rx), .mgmt(mgmt), .module_on(module_on), .rx_halt(rx_halt),
    .packet_pending_flag(pend), .packet_pending_irq(irq));
  msm_mgmt_model i_mgmt (.clk(clk), .srst(srst), .go(go), .scan_on(scan_on), .lf(lf),
    .mgmt(mgmt));

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One access; inc adds a one-descriptor packet at the same edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
      input msm_pkg::msm_size_e s = msm_pkg::sz_word, input logic inc = 1'b0);
    @(negedge clk);
    req = '{wr: w, rd: !w, size: s, addr: a, wdata: wd};
    rx.pkt_done = inc;
    rx.desc_used = 8'h01;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    rx.pkt_done = 1'b0;
    if (!w) begin
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clk);
      if (rvalid !== 1'b1) begin
        err_count++;
        conclude();
      end else begin
        d = rdata;
      end
    end
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0000_0000);
    chk(n, d, exp);
  endtask

  task automatic pkt(input logic [7:0] n);
    @(negedge clk);
    rx.pkt_done = 1'b1;
    rx.desc_used = n;
    @(negedge clk);
    rx.pkt_done = 1'b0;
  endtask

  task automatic s_reset;
    rdc("status reset", 8'h00, 32'h0000_0000);
    rdc("mind reset", 8'h10, 32'h0000_0000);
  endtask

  task automatic s_count;
    acc(1'b1, 8'h20, 32'h0000_8080);
    acc(1'b1, 8'h38, 32'h0000_0040);
    pkt(8'h03);
    rdc("count three", 8'h00, 32'h0003_0080);
    chk("pending irq", 32'({pend, irq}), 32'h0000_0003);
    pkt(8'hfe);
    rdc("saturate", 8'h00, 32'h00ff_0080);
    chk("halt at max", 32'(rx_halt), 32'h0000_0001);
    acc(1'b1, 8'h28, 32'h0000_0001);
    chk("halt released", 32'(rx_halt), 32'h0000_0000);
    acc(1'b1, 8'h28, 32'h0000_0001, msm_pkg::sz_word, 1'b1);
    rdc("inc with dec", 8'h00, 32'h00fe_0080);
    acc(1'b1, 8'h34, 32'h0000_0040);
    chk("irq masked", 32'({pend, irq}), 32'h0000_0002);
  endtask

  task automatic s_afc_off;
    acc(1'b1, 8'h24, 32'h0000_0080);
    pkt(8'h02);
    rdc("no wrap", 8'h00, 32'h00ff_0080);
    chk("no halt", 32'(rx_halt), 32'h0000_0000);
    pkt(8'h01);
    rdc("stay at max", 8'h00, 32'h00ff_0080);
    chk("no halt at max", 32'(rx_halt), 32'h0000_0000);
  endtask

  task automatic s_power;
    rx.tx_active = 1'b1;
    rx.rx_active = 1'b1;
    acc(1'b1, 8'h24, 32'h0000_8000);
    chk("module off", 32'(module_on), 32'h0000_0000);
    rdc("off keeps count", 8'h00, 32'h00ff_0000);
    rx.txn_pending = 1'b1;
    rdc("finishing", 8'h00, 32'h00ff_0080);
    rx.txn_pending = 1'b0;
    acc(1'b1, 8'h28, 32'h0000_8000);
    chk("module on", 32'(module_on), 32'h0000_0001);
    rdc("tx rx busy", 8'h00, 32'h00ff_00e0);
    acc(1'b1, 8'h40, 32'h0000_0000);
    rdc("start clears", 8'h00, 32'h0000_00e0);
    acc(1'b1, 8'h28, 32'h0000_0001);
    rdc("floor", 8'h00, 32'h0000_00e0);
    chk("no pending", 32'(pend), 32'h0000_0000);
    rx.tx_active = 1'b0;
    rx.rx_active = 1'b0;
  endtask

  task automatic s_size;
    acc(1'b1, 8'h38, 32'h0000_0040, msm_pkg::sz_byte);
    rdc("byte ignored", 8'h30, 32'h0000_0000);
    acc(1'b1, 8'h38, 32'h0000_0040, msm_pkg::sz_half);
    rdc("half write", 8'h30, 32'h0000_0040);
    acc(1'b1, 8'h3c, 32'h0000_0040);
    rdc("invert", 8'h30, 32'h0000_0000);
    rdc("unmapped", 8'h80, 32'h0000_0000);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, size: msm_pkg::sz_byte, addr: 8'h30, wdata: 32'h0000_0000};
    @(negedge clk);
    req.rd = 1'b0;
    chk("byte read", 32'(rvalid), 32'h0000_0000);
  endtask

  task automatic s_mgmt;
    @(negedge clk);
    scan_on = 1'b1;
    lf = 1'b1;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    rdc("mgmt running", 8'h10, 32'h0000_0007);
    scan_on = 1'b0;
    repeat (4) @(negedge clk);
    rdc("mgmt done", 8'h10, 32'h0000_0008);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    go = 1'b0;
    scan_on = 1'b0;
    lf = 1'b0;
    req = '0;
    rx = '0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    s_reset();
    s_count();
    s_afc_off();
    s_power();
    s_size();
    s_mgmt();
    conclude();
  end
endmodule
